// >>> design/adcpm_pkg.sv
// constants and types for the converter port pins and multiplexer address block
// assumes a 32-bit AHB-Lite fabric; the slave decodes only the low address byte
package adcpm_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
  localparam logic [7:0] OFS_PORT_B_DATA = 8'h04;
  localparam logic [7:0] OFS_PORT_A_DIR  = 8'h08;
  localparam logic [7:0] OFS_CTRL        = 8'h0c;
  localparam logic [7:0] OFS_STATUS      = 8'h10;

  // control register fields
  localparam int CTRL_MUX_EN    = 0;
  localparam int CTRL_TRIG1_EN  = 1;
  localparam int CTRL_TRIG2_EN  = 2;
  localparam int CTRL_WIDTH     = 3;

  // reset values
  localparam logic [7:0]            PORT_A_DATA_RST = 8'h00;
  localparam logic [7:0]            PORT_A_DIR_RST  = 8'h00;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST        = 3'h0;

  // channel to pin mapping
  localparam logic [5:0] CHAN_LOW_LAST   = 6'h03;
  localparam logic [5:0] CHAN_EXT_LIMIT  = 6'h20;
  localparam logic [5:0] CHAN_HIGH_FIRST = 6'h30;
  localparam logic [5:0] CHAN_HIGH_LAST  = 6'h3b;
  localparam logic [5:0] CHAN_SHARED_FST = 6'h34;
  localparam logic [5:0] CHAN_SHARED_LST = 6'h36;
  localparam logic [5:0] CHAN_PIN_OFS    = 6'h2c;
  localparam logic [7:0] MUX_ADDR_PINS   = 8'h07;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SYNC = 4'h2,
    ST_LOAD = 4'h4,
    ST_RESP = 4'h8
  } adcpm_fsm_e;

  typedef struct packed {
    adcpm_fsm_e            fsm;
    logic [7:0]            addr;
    logic                  write;
    logic [7:0]            dir;
    logic [7:0]            data_a;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [7:0]            sync1_a;
    logic [7:0]            sync1_b;
    logic [7:0]            sync2_a;
    logic [7:0]            sync2_b;
    logic [31:0]           hrdata;
    logic                  hready;
    logic                  hresp;
    logic [7:0]            pa_out;
    logic [7:0]            pa_oe;
    logic [2:0]            mux_addr;
    logic [3:0]            pin_sel;
    logic                  pin_valid;
    logic [1:0]            trig_prev;
    logic [1:0]            trig_pulse;
  } adcpm_state_s;

endpackage : adcpm_pkg

// >>> design/adcpm_port_pins.sv
// digital port pins, trigger inputs and external multiplexer address of the converter
// assumes one AHB-Lite master, pins already synchronous to clock_i, sequencer supplies
// the channel field of the command word being executed
//
// Behaviour
// - port A is an 8-bit bidirectional port
// - each direction bit picks its pin's direction
// - input pins read back through port A data
// - output bits of data drive their pins
// - port A reads pass a synchroniser
// - port A read returns all eight pins
// - port B is input-only, no direction register
// - port B reads pass a synchroniser
// - port B read returns all eight pins
// - two trigger inputs, one per queue
// - trigger pin is input in trigger mode
// - no external mux: sixteen pins routed internally
// - external mux: 3-bit address to four muxes
// - address pins are mux address or GPIO
// - mux mode forces address pins from command
// - three analog pins shared with address outputs
// - up to 41 channels addressable in total
// - synchroniser enabled only by port data decode
// - mux inputs carry even/odd channel groups
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module adcpm_port_pins
  import adcpm_pkg::*;
(
  input  wire logic        clock_i,                        // 40 MHz bus clock
  input  wire logic        sys_rst_i,                      // synchronous reset, high
  input  wire logic        hsel_i,                         // slave select
  input  wire logic [31:0] haddr_i,                        // byte address
  input  wire logic [1:0]  htrans_i,                       // transfer type
  input  wire logic        hwrite_i,                       // write when high
  input  wire logic [2:0]  hsize_i,                        // word only
  input  wire logic        hready_i,                       // bus ready
  input  wire logic [31:0] hwdata_i,                       // write data
  output logic      [31:0] hrdata_o,                       // read data
  output logic             hreadyout_o,                    // slave ready
  output logic             hresp_o,                        // always okay
  input  wire logic [7:0]  port_a_digital_i,               // port A pin levels
  output logic      [7:0]  port_a_digital_o,               // port A drive value
  output logic      [7:0]  port_a_digital_oe_o,            // port A drive enable
  input  wire logic [7:0]  port_b_digital_i,               // port B pin levels
  input  wire logic [1:0]  ext_trigger_pin_i,              // queue 2..1 trigger pins
  output logic      [1:0]  ext_trigger_o,                  // rising edge pulses
  input  wire logic [5:0]  conversion_command_word_chan_i, // executing channel
  output logic      [2:0]  mux_address_out_o,              // external mux address
  output logic      [3:0]  converter_pin_sel_o,            // internal mux pin index
  output logic             converter_pin_valid_o           // channel maps to a pin
);

  localparam adcpm_state_s STATE_RST = '{fsm: ST_IDLE, hready: 1'b1, default: '0};

  adcpm_state_s r_reg;
  adcpm_state_s r_next;
  logic         take;

  function automatic logic is_port_data(input logic [7:0] a);
    is_port_data = (a == OFS_PORT_A_DATA) || (a == OFS_PORT_B_DATA);
  endfunction : is_port_data

  // returns {valid, pin index}; pins 0..3 are port B low, 4..7 port B high, 8..15 port A
  function automatic logic [4:0] chan_to_pin(input logic [5:0] ch, input logic mux_en);
    logic [5:0] off;
    off = ch - CHAN_PIN_OFS;
    chan_to_pin = 5'h00;
    if (mux_en && ch < CHAN_EXT_LIMIT) begin
      chan_to_pin = {1'b1, 2'h0, ch[4], ch[0]};
    end else if (!mux_en && ch <= CHAN_LOW_LAST) begin
      chan_to_pin = {1'b1, ch[3:0]};
    end else if (ch >= CHAN_HIGH_FIRST && ch <= CHAN_HIGH_LAST) begin
      // the shared pins carry the address while muxing, so they hold no channel
      if (!(mux_en && ch >= CHAN_SHARED_FST && ch <= CHAN_SHARED_LST)) begin
        chan_to_pin = {1'b1, off[3:0]};
      end
    end
  endfunction : chan_to_pin

  function automatic logic [31:0] read_mux(input adcpm_state_s s);
    read_mux = 32'h0000_0000;
    case (s.addr)
      OFS_PORT_A_DATA: read_mux = {24'h00_0000, s.sync2_a};
      OFS_PORT_B_DATA: read_mux = {24'h00_0000, s.sync2_b};
      OFS_PORT_A_DIR:  read_mux = {24'h00_0000, s.dir};
      OFS_CTRL:        read_mux = {29'h0000_0000, s.ctrl};
      OFS_STATUS:      read_mux = {24'h00_0000, s.pin_valid, s.pin_sel, s.mux_addr};
      default:         read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  assign take = hsel_i && (htrans_i == HTRANS_NONSEQ) && hready_i;

  always_comb begin
    logic [4:0] pin_map;
    logic       mux_en;
    pin_map = 5'h00;
    mux_en  = r_reg.ctrl[CTRL_MUX_EN];
    r_next  = r_reg;
    r_next.hresp = 1'b0;

    case (r_reg.fsm)
      ST_IDLE, ST_RESP: begin
        if (take) begin
          r_next.addr   = haddr_i[7:0];
          r_next.write  = hwrite_i;
          r_next.hready = 1'b0;
          // pins only enter the synchroniser when a port data read is decoded
          if (!hwrite_i && is_port_data(haddr_i[7:0])) begin
            r_next.sync1_a = port_a_digital_i;
            r_next.sync1_b = port_b_digital_i;
            r_next.fsm     = ST_SYNC;
          end else begin
            r_next.fsm = ST_LOAD;
          end
        end else begin
          r_next.hready = 1'b1;
          r_next.fsm    = ST_IDLE;
        end
      end
      ST_SYNC: begin
        r_next.sync2_a = r_reg.sync1_a;
        r_next.sync2_b = r_reg.sync1_b;
        r_next.fsm     = ST_LOAD;
      end
      ST_LOAD: begin
        if (r_reg.write) begin
          case (r_reg.addr)
            OFS_PORT_A_DATA: r_next.data_a = hwdata_i[7:0];
            OFS_PORT_A_DIR:  r_next.dir    = hwdata_i[7:0];
            OFS_CTRL:        r_next.ctrl   = hwdata_i[CTRL_WIDTH-1:0];
            default:         r_next.ctrl   = r_reg.ctrl; // port B has no writable state
          endcase
        end else begin
          r_next.hrdata = read_mux(r_reg);
        end
        r_next.hready = 1'b1;
        r_next.fsm    = ST_RESP;
      end
      default: begin
        r_next.hready = 1'b1;
        r_next.fsm    = ST_IDLE;
      end
    endcase

    // pin drive; address pins are taken over while external muxing is on
    r_next.mux_addr = mux_en ? conversion_command_word_chan_i[3:1] : 3'h0;
    if (mux_en) begin
      r_next.pa_out = {r_reg.data_a[7:3], r_next.mux_addr};
      r_next.pa_oe  = r_reg.dir | MUX_ADDR_PINS;
    end else begin
      r_next.pa_out = r_reg.data_a;
      r_next.pa_oe  = r_reg.dir;
    end

    pin_map = chan_to_pin(conversion_command_word_chan_i, mux_en);
    r_next.pin_valid = pin_map[4];
    r_next.pin_sel   = pin_map[3:0];

    // a trigger pin is looked at only while its queue is in trigger mode
    r_next.trig_prev  = ext_trigger_pin_i &
                        {r_reg.ctrl[CTRL_TRIG2_EN], r_reg.ctrl[CTRL_TRIG1_EN]};
    r_next.trig_pulse = r_next.trig_prev & ~r_reg.trig_prev;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      r_reg <= STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata_o              = r_reg.hrdata;
  assign hreadyout_o           = r_reg.hready;
  assign hresp_o               = r_reg.hresp;
  assign port_a_digital_o      = r_reg.pa_out;
  assign port_a_digital_oe_o   = r_reg.pa_oe;
  assign ext_trigger_o         = r_reg.trig_pulse;
  assign mux_address_out_o     = r_reg.mux_addr;
  assign converter_pin_sel_o   = r_reg.pin_sel;
  assign converter_pin_valid_o = r_reg.pin_valid;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence seq_read_a;
    take && !hwrite_i && haddr_i[7:0] == OFS_PORT_A_DATA;
  endsequence

  sequence seq_read_b;
    take && !hwrite_i && haddr_i[7:0] == OFS_PORT_B_DATA;
  endsequence

  sequence seq_write_a;
    take && hwrite_i && haddr_i[7:0] == OFS_PORT_A_DATA;
  endsequence

  sequence seq_trig1_rise;
    r_reg.ctrl[CTRL_TRIG1_EN] && !ext_trigger_pin_i[0]
      ##1 r_reg.ctrl[CTRL_TRIG1_EN] && ext_trigger_pin_i[0];
  endsequence

  sequence seq_trig2_rise;
    r_reg.ctrl[CTRL_TRIG2_EN] && !ext_trigger_pin_i[1]
      ##1 r_reg.ctrl[CTRL_TRIG2_EN] && ext_trigger_pin_i[1];
  endsequence

  sequence seq_write_dir;
    take && hwrite_i && haddr_i[7:0] == OFS_PORT_A_DIR;
  endsequence

  sequence seq_read_dir;
    take && !hwrite_i && haddr_i[7:0] == OFS_PORT_A_DIR;
  endsequence

  sequence seq_short_xfer;
    take && (hwrite_i || !is_port_data(haddr_i[7:0]));
  endsequence

  sequence seq_write_ctrl;
    take && hwrite_i && haddr_i[7:0] == OFS_CTRL;
  endsequence

  a_port_a_read: assert property (
    seq_read_a |-> ##3 hreadyout_o && hrdata_o[7:0] == $past(port_a_digital_i, 3))
    else $error("port A read does not return sampled pins");

  a_port_b_read: assert property (
    seq_read_b |=> !hreadyout_o [*2] ##1 hreadyout_o
      && hrdata_o[7:0] == $past(port_b_digital_i, 3))
    else $error("port B read does not return sampled pins");

  a_sync_gated: assert property (
    !(take && !hwrite_i && is_port_data(haddr_i[7:0])) |=> $stable(r_reg.sync1_a))
    else $error("synchroniser loaded without a port data read");

  a_data_store: assert property (
    seq_write_a |-> ##2 r_reg.data_a == $past(hwdata_i) && hreadyout_o)
    else $error("port A data write not stored");

  a_dir_drive: assert property (
    !r_reg.ctrl[CTRL_MUX_EN] |=> port_a_digital_oe_o == $past(r_reg.dir)
      && port_a_digital_o == $past(r_reg.data_a))
    else $error("port A drive does not follow direction and data");

  a_mux_force: assert property (
    r_reg.ctrl[CTRL_MUX_EN] |=> port_a_digital_oe_o[2:0] == 3'h7
      && port_a_digital_o[2:0] == $past(conversion_command_word_chan_i[3:1]))
    else $error("address pins not forced from command channel");

  a_trig_edge: assert property (
    seq_trig1_rise |=> ext_trigger_o[0])
    else $error("trigger edge not reported");

  a_trig_off: assert property (
    !r_reg.ctrl[CTRL_TRIG2_EN] |=> !ext_trigger_o[1])
    else $error("trigger pulse while queue not in trigger mode");

  a_ext_group: assert property (
    r_reg.ctrl[CTRL_MUX_EN] && conversion_command_word_chan_i < CHAN_EXT_LIMIT |=>
      converter_pin_valid_o && converter_pin_sel_o ==
      {2'h0, $past(conversion_command_word_chan_i[4]), $past(conversion_command_word_chan_i[0])})
    else $error("external channel routed to wrong group pin");

  a_shared_pins: assert property (
    r_reg.ctrl[CTRL_MUX_EN] && conversion_command_word_chan_i >= CHAN_SHARED_FST
      && conversion_command_word_chan_i <= CHAN_SHARED_LST |=> !converter_pin_valid_o)
    else $error("shared address pin used as channel");

  a_direct_chan: assert property (
    !r_reg.ctrl[CTRL_MUX_EN] && conversion_command_word_chan_i <= CHAN_LOW_LAST |=>
      converter_pin_valid_o && converter_pin_sel_o == $past(conversion_command_word_chan_i[3:0]))
    else $error("direct channel routed to wrong pin");

  // only port data reads pay for the synchroniser stages
  a_short_wait: assert property (
    seq_short_xfer |=> !hreadyout_o ##1 hreadyout_o)
    else $error("register transfer did not answer after one wait");

  a_dir_store: assert property (
    seq_write_dir |-> ##2 r_reg.dir == $past(hwdata_i[7:0]))
    else $error("direction write not stored");

  a_dir_read: assert property (
    seq_read_dir |-> ##2 hreadyout_o && hrdata_o == {24'h00_0000, $past(r_reg.dir)})
    else $error("direction read does not return stored bits");

  a_ctrl_store: assert property (
    seq_write_ctrl |-> ##2 r_reg.ctrl == $past(hwdata_i[CTRL_WIDTH-1:0]))
    else $error("control write not stored");

  a_mux_addr: assert property (
    r_reg.ctrl[CTRL_MUX_EN] |=>
      mux_address_out_o == $past(conversion_command_word_chan_i[3:1]))
    else $error("mux address does not follow command channel");

  a_mux_idle: assert property (
    !r_reg.ctrl[CTRL_MUX_EN] |=> mux_address_out_o == 3'h0)
    else $error("mux address driven while external muxing is off");

  a_mux_upper: assert property (
    r_reg.ctrl[CTRL_MUX_EN] |=> port_a_digital_oe_o[7:3] == $past(r_reg.dir[7:3])
      && port_a_digital_o[7:3] == $past(r_reg.data_a[7:3]))
    else $error("port A upper pins disturbed by muxing");

  a_trig2_edge: assert property (
    seq_trig2_rise |=> ext_trigger_o[1])
    else $error("queue 2 trigger edge not reported");

  a_trig_pulse: assert property (
    ext_trigger_o != 2'h0 |=> (ext_trigger_o & $past(ext_trigger_o)) == 2'h0)
    else $error("trigger pulse stands longer than one cycle");

  a_trig1_off: assert property (
    !r_reg.ctrl[CTRL_TRIG1_EN] |=> !ext_trigger_o[0])
    else $error("queue 1 trigger pulse while not in trigger mode");

  a_high_direct: assert property (
    !r_reg.ctrl[CTRL_MUX_EN] && conversion_command_word_chan_i >= CHAN_HIGH_FIRST
      && conversion_command_word_chan_i <= CHAN_HIGH_LAST |=> converter_pin_valid_o
      && converter_pin_sel_o == $past(conversion_command_word_chan_i[3:0]) + 4'h4)
    else $error("high channel routed to wrong pin");

  // in mux mode the high channels stay direct, except the three address pins
  a_high_mux: assert property (
    r_reg.ctrl[CTRL_MUX_EN] && conversion_command_word_chan_i >= CHAN_HIGH_FIRST
      && conversion_command_word_chan_i <= CHAN_HIGH_LAST
      && !(conversion_command_word_chan_i >= CHAN_SHARED_FST
      && conversion_command_word_chan_i <= CHAN_SHARED_LST) |=> converter_pin_valid_o
      && converter_pin_sel_o == $past(conversion_command_word_chan_i[3:0]) + 4'h4)
    else $error("high channel routed to wrong pin in mux mode");

  a_gap_invalid: assert property (
    conversion_command_word_chan_i > CHAN_LOW_LAST
      && conversion_command_word_chan_i < CHAN_HIGH_FIRST
      && !(r_reg.ctrl[CTRL_MUX_EN] && conversion_command_word_chan_i < CHAN_EXT_LIMIT)
      |=> !converter_pin_valid_o)
    else $error("unmapped channel reported as valid");

  a_top_invalid: assert property (
    conversion_command_word_chan_i > CHAN_HIGH_LAST |=> !converter_pin_valid_o)
    else $error("channel above the pin range reported as valid");

  a_sync_stage: assert property (
    r_reg.fsm == ST_SYNC |=> r_reg.sync2_a == $past(r_reg.sync1_a)
      && r_reg.sync2_b == $past(r_reg.sync1_b))
    else $error("second synchroniser stage not loaded from the first");

  a_data_keep: assert property (
    take && hwrite_i && haddr_i[7:0] != OFS_PORT_A_DATA |=> ##1 $stable(r_reg.data_a))
    else $error("port A data changed by a write elsewhere");

endmodule : adcpm_port_pins

// >>> verif/adcpm_pin_model.sv
// far side of the port pins: a board that drives the port A pins the block leaves undriven
// assumes the block's enables and drive values arrive straight from its ports
`timescale 1ns/1ps
module adcpm_pin_model (
  input  wire logic [7:0] drive_i,    // block drive value
  input  wire logic [7:0] drive_oe_i, // block drive enable
  input  wire logic [7:0] board_i,    // level the board puts on free pins
  output logic      [7:0] pin_o       // resolved pin level
);
  // a pin the block drives shows the block's value, a free one shows the board's
  assign pin_o = (drive_i & drive_oe_i) | (board_i & ~drive_oe_i);
endmodule : adcpm_pin_model

// >>> verif/tb.sv
// register and pin tests for the converter port pins block
// assumes one AHB-Lite master; the pin model stands on the port A pins
`timescale 1ns/1ps
module tb;
  import adcpm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdy, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, trig = 2'h0, trig_o;
  logic [7:0]  pa_pin, pa_o, pa_oe, pb = 8'h96, board = 8'h3c;
  logic [5:0]  chan = 6'h00;
  logic [2:0]  mux;
  logic [3:0]  psel;
  logic        pvalid;
  int          err_count = 0;
  int          tests_run = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  adcpm_port_pins u_adcpm_port_pins (.clock_i(clk), .sys_rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(rdy),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(hresp),
    .port_a_digital_i(pa_pin), .port_a_digital_o(pa_o), .port_a_digital_oe_o(pa_oe),
    .port_b_digital_i(pb), .ext_trigger_pin_i(trig), .ext_trigger_o(trig_o),
    .conversion_command_word_chan_i(chan), .mux_address_out_o(mux),
    .converter_pin_sel_o(psel), .converter_pin_valid_o(pvalid));
  adcpm_pin_model u_adcpm_pin_model (.drive_i(pa_o), .drive_oe_i(pa_oe), .board_i(board),
    .pin_o(pa_pin));
  task finish_test;
    $display("tests %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // holds each phase until hready is sampled high, as the bus requires
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        finish_test();
      end
      @(posedge clk);
    end
  endtask : wait_ready
  task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  task settle;
    // ends on an edge, so the next stimulus lands on the edge as well
    repeat (3) @(posedge clk);
  endtask : settle
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFS_PORT_A_DIR, 32'h0);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_PORT_A_DATA, 32'h3c);
    $display("test reset done");
    bus(OFS_PORT_A_DIR, 1'b1, 32'hf0);
    bus(OFS_PORT_A_DATA, 1'b1, 32'ha5);
    settle();
    check(pa_oe, 8'hf0);
    check(pa_o & pa_oe, 8'ha0);
    check(pa_pin, 8'hac);
    rd_chk(OFS_PORT_A_DATA, 32'hac);
    bus(OFS_PORT_A_DIR, 1'b1, 32'hff);
    settle();
    check(pa_pin, 8'ha5);
    bus(OFS_PORT_A_DIR, 1'b1, 32'hf0);
    $display("test port a done");
    rd_chk(OFS_PORT_B_DATA, 32'h96);
    bus(OFS_PORT_B_DATA, 1'b1, 32'h11);
    pb <= 8'h5a;
    rd_chk(OFS_PORT_B_DATA, 32'h5a);
    rd_chk(8'h14, 32'h0);
    $display("test port b done");
    chan <= 6'h3b;
    settle();
    check({pvalid, psel}, 5'h1f);
    chan <= 6'h1d;
    settle();
    check(pvalid, 1'b0);
    check(mux, 3'h0);
    bus(OFS_CTRL, 1'b1, 32'h1);
    settle();
    check(mux, 3'h6);
    check(pa_oe, 8'hf7);
    check(pa_o[2:0], 3'h6);
    rd_chk(OFS_STATUS, 32'h9e);
    chan <= 6'h35;
    settle();
    check(pvalid, 1'b0);
    $display("test mux done");
    bus(OFS_CTRL, 1'b1, 32'h2);
    trig <= 2'h3;
    @(posedge clk);
    check(trig_o, 2'h0);
    @(posedge clk);
    check(trig_o, 2'h1);
    @(posedge clk);
    check(trig_o, 2'h0);
    @(posedge clk);
    trig <= 2'h0;
    bus(OFS_CTRL, 1'b1, 32'h4);
    trig <= 2'h3;
    repeat (2) @(posedge clk);
    check(trig_o, 2'h2);
    $display("test trigger done");
    finish_test();
  end
endmodule : tb
